// ### hdl/dmcc_pkg.sv
// constants and types shared by the descriptor chaining channel
package dmcc_pkg;
   // ==========================================================
   // address map
   localparam logic [31:0] MAIN_BANK_BASE = 32'h7E00_7000;
   localparam logic [31:0] CHANNEL_STRIDE = 32'h0000_0100;
   localparam logic [31:0] REMOTE_CHANNEL_BASE = 32'h7EE0_5000;
   localparam logic [31:0] ENABLE_OFFSET = 32'h0000_0FF0;
   localparam logic [3:0] REMOTE_CHANNEL_ID = 4'hF;
   localparam int CHANNEL_SPAN_BITS = 8;
   localparam int ENABLE_SPAN_BITS = 2;
   // ==========================================================
   // register offsets inside one channel window
   localparam logic [7:0] CS_OFFSET = 8'h00;
   localparam logic [7:0] POINTER_OFFSET = 8'h04;
   localparam logic [7:0] WORD0_OFFSET = 8'h08;
   localparam logic [7:0] DEBUG_OFFSET_STD = 8'h20;
   localparam logic [7:0] DEBUG_OFFSET_WIDE = 8'h24;
   // ==========================================================
   // control-status fields and reset values
   localparam int CS_RUN_BIT = 0;
   localparam int CS_FETCH_BIT = 1;
   localparam int CS_BUSY_BIT = 2;
   localparam logic [15:0] ENABLE_RESET = 16'hFFFF;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   // ==========================================================
   // descriptor layout
   localparam int DESC_WORDS = 8;
   localparam int ALIGN_BITS = 5;
   localparam logic [31:0] MOVER_STEP_BYTES = 32'h0000_0004;
   localparam logic [3:0] FIRST_REDUCED = 4'h7;
   localparam logic [3:0] LAST_REDUCED = 4'hA;
   localparam logic [3:0] FIRST_WIDE = 4'hB;
   localparam logic [3:0] LAST_WIDE = 4'hE;
   localparam int REDUCED_HOLE = 4;
   // ==========================================================
   // types
   typedef enum logic [1:0] {FMT_STANDARD = 2'h0, FMT_REDUCED = 2'h1, FMT_WIDE = 2'h2} dmcc_format_e;
   typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_FETCH = 2'h1, ST_XFER = 2'h3, ST_LINK = 2'h2} dmcc_state_e;
endpackage

// ### hdl/dmcc_window_match.sv
// address window comparator for one register window
`timescale 1ns/1ns
module dmcc_window_match #(
   parameter logic [31:0] BASE = 32'h0000_0000,
   parameter int SPAN_BITS = 8
) (
   // address in
   input wire logic [31:0] addr_in,
   // match out
   output logic hit_out,
   output logic [7:0] offset_out
);
   // compare the bits above the window span
   assign hit_out = (addr_in[31:SPAN_BITS] == BASE[31:SPAN_BITS]);
   assign offset_out = addr_in[7:0];
endmodule

// ### hdl/dmcc_channel.sv
// descriptor fetch and chaining engine for one channel
`timescale 1ns/1ns
module dmcc_channel #(
   parameter logic [3:0] CHANNEL_ID = 4'h0
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // software register port
   input wire logic [31:0] sw_addr_in,
   input wire logic sw_write_in,
   input wire logic sw_read_in,
   input wire logic [31:0] sw_wdata_in,
   input wire logic sw_vector_in,
   output logic [31:0] sw_rdata_out,
   output logic sw_rvalid_out,
   // descriptor fetch from memory
   output logic mem_req_out,
   output logic [31:0] mem_addr_out,
   input wire logic mem_ready_in,
   input wire logic mem_rvalid_in,
   input wire logic [31:0] mem_rdata_in,
   // data mover side
   input wire logic mover_step_in,
   output logic xfer_active_out,
   output logic [31:0] xfer_source_out,
   output logic [31:0] xfer_wide_destination_pointer_out
);
   // ==========================================================
   // channel format and word positions
   localparam dmcc_pkg::dmcc_format_e FORMAT =
      (CHANNEL_ID >= dmcc_pkg::FIRST_WIDE && CHANNEL_ID <= dmcc_pkg::LAST_WIDE) ? dmcc_pkg::FMT_WIDE :
      (CHANNEL_ID >= dmcc_pkg::FIRST_REDUCED && CHANNEL_ID <= dmcc_pkg::LAST_REDUCED) ? dmcc_pkg::FMT_REDUCED :
      dmcc_pkg::FMT_STANDARD;
   localparam bit IS_WIDE = (FORMAT == dmcc_pkg::FMT_WIDE);
   localparam int SRC_IDX = 1;
   localparam int DST_IDX = IS_WIDE ? 3 : 2;
   localparam int LEN_IDX = IS_WIDE ? 5 : 3;
   localparam int NEXT_IDX = IS_WIDE ? 6 : 5;
   localparam logic [7:0] DEBUG_OFFSET = IS_WIDE ? dmcc_pkg::DEBUG_OFFSET_WIDE : dmcc_pkg::DEBUG_OFFSET_STD;
   localparam logic [31:0] CHANNEL_BASE = (CHANNEL_ID == dmcc_pkg::REMOTE_CHANNEL_ID) ?
      dmcc_pkg::REMOTE_CHANNEL_BASE : dmcc_pkg::MAIN_BANK_BASE + 32'(CHANNEL_ID) * dmcc_pkg::CHANNEL_STRIDE;
   localparam logic [31:0] ENABLE_ADDR = dmcc_pkg::MAIN_BANK_BASE + dmcc_pkg::ENABLE_OFFSET;

   // true for descriptor words that carry meaning in this format
   function automatic bit word_kept(input int k);
      if (IS_WIDE)
      begin
         return k <= NEXT_IDX;
      end
      return (k <= NEXT_IDX) && !((FORMAT == dmcc_pkg::FMT_REDUCED) && (k == dmcc_pkg::REDUCED_HOLE));
   endfunction

   // ==========================================================
   // state
   dmcc_pkg::dmcc_state_e state, next_state;
   logic run, next_run;
   logic [31:0] ptr, next_ptr;
   logic [31:0] debug_word, next_debug_word;
   logic [15:0] enable, next_enable;
   logic [2:0] word_idx, next_word_idx;
   logic pending, next_pending;
   logic [31:0] desc [0:dmcc_pkg::DESC_WORDS-1];
   logic [31:0] next_desc [0:dmcc_pkg::DESC_WORDS-1];
   logic [31:0] next_rdata;
   logic next_rvalid;

   // ==========================================================
   // address decode
   logic chan_hit, en_hit, access_ok, chan_en;
   logic [7:0] chan_off;
   logic cs_write, ptr_write;

   // channel register window
   dmcc_window_match #(.BASE(CHANNEL_BASE), .SPAN_BITS(dmcc_pkg::CHANNEL_SPAN_BITS)) chan_window (
      .addr_in(sw_addr_in),
      .hit_out(chan_hit),
      .offset_out(chan_off)
   );

   // controller-level enable register window
   dmcc_window_match #(.BASE(ENABLE_ADDR), .SPAN_BITS(dmcc_pkg::ENABLE_SPAN_BITS)) enable_window (
      .addr_in(sw_addr_in),
      .hit_out(en_hit),
      .offset_out()
   );

   // remote channel answers the vector processor only
   assign access_ok = chan_hit && ((CHANNEL_ID != dmcc_pkg::REMOTE_CHANNEL_ID) || sw_vector_in);
   assign chan_en = enable[CHANNEL_ID];
   assign cs_write = sw_write_in && access_ok && (chan_off == dmcc_pkg::CS_OFFSET);
   assign ptr_write = sw_write_in && access_ok && (chan_off == dmcc_pkg::POINTER_OFFSET);

   // ==========================================================
   // outputs toward memory and mover
   // low five bits dropped: descriptors are 256-bit aligned
   assign mem_req_out = (state == dmcc_pkg::ST_FETCH) && run && chan_en && !pending;
   assign mem_addr_out = {ptr[31:dmcc_pkg::ALIGN_BITS], word_idx, 2'h0};
   assign xfer_active_out = (state == dmcc_pkg::ST_XFER) && run && chan_en;
   assign xfer_source_out = desc[SRC_IDX];
   assign xfer_wide_destination_pointer_out = desc[DST_IDX];

   // ==========================================================
   // next-state logic for engine, registers and read port
   always_comb
   begin
      next_state = state;
      next_run = run;
      next_ptr = ptr;
      next_debug_word = debug_word;
      next_enable = enable;
      next_word_idx = word_idx;
      next_pending = pending;
      next_desc = desc;
      next_rdata = sw_rdata_out;
      next_rvalid = 1'b0;
      case (state)
         dmcc_pkg::ST_IDLE:
         begin
            if (run && chan_en)
            begin
               next_state = dmcc_pkg::ST_FETCH;
               next_word_idx = 3'h0;
            end
         end
         dmcc_pkg::ST_FETCH:
         begin
            if (mem_req_out && mem_ready_in)
            begin
               next_pending = 1'b1;
            end
            if (pending && mem_rvalid_in)
            begin
               next_pending = 1'b0;
               // reserved words are dropped, never stored
               for (int k = 0; k < dmcc_pkg::DESC_WORDS; k++)
               begin
                  if (word_kept(k) && (32'(k) == 32'(word_idx)))
                  begin
                     next_desc[k] = mem_rdata_in;
                  end
               end
               next_word_idx = word_idx + 3'h1;
               if (word_idx == 3'(dmcc_pkg::DESC_WORDS - 1))
               begin
                  next_state = dmcc_pkg::ST_XFER;
               end
            end
         end
         dmcc_pkg::ST_XFER:
         begin
            if (desc[LEN_IDX] == 32'h0000_0000)
            begin
               next_state = dmcc_pkg::ST_LINK;
            end
            else if (xfer_active_out && mover_step_in)
            begin
               // live progress of the running transfer
               next_desc[SRC_IDX] = desc[SRC_IDX] + dmcc_pkg::MOVER_STEP_BYTES;
               next_desc[DST_IDX] = desc[DST_IDX] + dmcc_pkg::MOVER_STEP_BYTES;
               next_desc[LEN_IDX] = (desc[LEN_IDX] > dmcc_pkg::MOVER_STEP_BYTES) ?
                  desc[LEN_IDX] - dmcc_pkg::MOVER_STEP_BYTES : 32'h0000_0000;
            end
         end
         dmcc_pkg::ST_LINK:
         begin
            next_ptr = desc[NEXT_IDX];
            next_word_idx = 3'h0;
            if (desc[NEXT_IDX] == 32'h0000_0000)
            begin
               next_run = 1'b0;
               next_state = dmcc_pkg::ST_IDLE;
            end
            else
            begin
               next_state = dmcc_pkg::ST_FETCH; // run stays set
            end
         end
         default:
         begin
            next_state = dmcc_pkg::ST_IDLE;
         end
      endcase
      // software writes come last so a run set wins over a hardware clear
      if (sw_write_in && en_hit)
      begin
         next_enable = sw_wdata_in[15:0];
      end
      if (sw_write_in && access_ok)
      begin
         if (chan_off == dmcc_pkg::CS_OFFSET)
         begin
            next_run = sw_wdata_in[dmcc_pkg::CS_RUN_BIT];
         end
         else if (chan_off == dmcc_pkg::POINTER_OFFSET)
         begin
            next_ptr = sw_wdata_in;
         end
         else if (chan_off == DEBUG_OFFSET)
         begin
            next_debug_word = sw_wdata_in;
         end
         else if (chan_off == dmcc_pkg::WORD0_OFFSET + 8'(4 * NEXT_IDX))
         begin
            next_desc[NEXT_IDX] = sw_wdata_in; // chain edit
         end
      end
      // registered read answer
      if (sw_read_in)
      begin
         next_rvalid = 1'b1;
         next_rdata = 32'h0000_0000;
         if (en_hit)
         begin
            next_rdata = {16'h0000, enable};
         end
         else if (access_ok)
         begin
            if (chan_off == dmcc_pkg::CS_OFFSET)
            begin
               next_rdata[dmcc_pkg::CS_RUN_BIT] = run;
               next_rdata[dmcc_pkg::CS_FETCH_BIT] = (state == dmcc_pkg::ST_FETCH);
               next_rdata[dmcc_pkg::CS_BUSY_BIT] = (state != dmcc_pkg::ST_IDLE);
            end
            else if (chan_off == dmcc_pkg::POINTER_OFFSET)
            begin
               next_rdata = ptr;
            end
            else if (chan_off == DEBUG_OFFSET)
            begin
               next_rdata = debug_word;
            end
            else if (chan_off >= dmcc_pkg::WORD0_OFFSET && chan_off <= dmcc_pkg::WORD0_OFFSET + 8'(4 * NEXT_IDX))
            begin
               next_rdata = desc[3'(chan_off[4:2] - 3'h2)];
            end
         end
      end
   end

   // registers
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         state <= dmcc_pkg::ST_IDLE;
         run <= 1'b0;
         ptr <= dmcc_pkg::WORD_RESET;
         debug_word <= dmcc_pkg::WORD_RESET;
         enable <= dmcc_pkg::ENABLE_RESET;
         word_idx <= 3'h0;
         pending <= 1'b0;
         sw_rdata_out <= dmcc_pkg::WORD_RESET;
         sw_rvalid_out <= 1'b0;
         for (int k = 0; k < dmcc_pkg::DESC_WORDS; k++)
         begin
            desc[k] <= dmcc_pkg::WORD_RESET;
         end
      end
      else
      begin
         state <= next_state;
         run <= next_run;
         ptr <= next_ptr;
         debug_word <= next_debug_word;
         enable <= next_enable;
         word_idx <= next_word_idx;
         pending <= next_pending;
         sw_rdata_out <= next_rdata;
         sw_rvalid_out <= next_rvalid;
         desc <= next_desc;
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);

   fetch_align_a: assert property (mem_req_out |-> mem_addr_out[31:5] == ptr[31:5] && mem_addr_out[4:0] == {word_idx, 2'h0})
      else $error("fetch address not inside aligned descriptor");
   start_fetch_a: assert property ((state == dmcc_pkg::ST_IDLE) && run && chan_en |=> (state == dmcc_pkg::ST_FETCH) && word_idx == 3'h0)
      else $error("run flag did not start a fetch");
   link_follow_a: assert property ((state == dmcc_pkg::ST_LINK) && desc[NEXT_IDX] != 32'h0 && !ptr_write && !cs_write
      |=> ptr == $past(desc[NEXT_IDX]) && (state == dmcc_pkg::ST_FETCH) && run)
      else $error("next pointer not followed");
   halt_zero_a: assert property ((state == dmcc_pkg::ST_LINK) && desc[NEXT_IDX] == 32'h0 && !cs_write && !ptr_write
      |=> !run && ptr == 32'h0 && (state == dmcc_pkg::ST_IDLE))
      else $error("chain end did not halt");
   done_link_a: assert property ((state == dmcc_pkg::ST_XFER) && desc[LEN_IDX] == 32'h0 |=> (state == dmcc_pkg::ST_LINK))
      else $error("zero length did not end transfer");
   run_held_a: assert property ((state == dmcc_pkg::ST_FETCH) && !cs_write |=> run)
      else $error("run flag dropped during fetch");
   reserved_zero_a: assert property (desc[dmcc_pkg::DESC_WORDS-1] == 32'h0 && (IS_WIDE || desc[6] == 32'h0))
      else $error("reserved descriptor word stored");
   reduced_hole_a: assert property ((FORMAT == dmcc_pkg::FMT_REDUCED) |-> desc[dmcc_pkg::REDUCED_HOLE] == 32'h0)
      else $error("reduced channel stored a stride");
   len_progress_a: assert property (xfer_active_out && mover_step_in && desc[LEN_IDX] > dmcc_pkg::MOVER_STEP_BYTES
      |=> desc[LEN_IDX] == $past(desc[LEN_IDX]) - dmcc_pkg::MOVER_STEP_BYTES && desc[SRC_IDX] == $past(desc[SRC_IDX]) + 32'h4)
      else $error("length progress wrong");
   word_readonly_a: assert property (sw_write_in && access_ok && chan_off >= dmcc_pkg::WORD0_OFFSET
      && chan_off < dmcc_pkg::WORD0_OFFSET + 8'(4 * NEXT_IDX) && (state == dmcc_pkg::ST_IDLE)
      |=> $stable(desc[0]) && $stable(desc[SRC_IDX]) && $stable(desc[DST_IDX]) && $stable(desc[LEN_IDX]))
      else $error("read-only word took a write");
   disabled_quiet_a: assert property (!chan_en |-> !mem_req_out && !xfer_active_out)
      else $error("disabled channel still active");

   chain_follow_c: cover property ((state == dmcc_pkg::ST_LINK) ##1 (state == dmcc_pkg::ST_FETCH));
   chain_halt_c: cover property ((state == dmcc_pkg::ST_LINK) ##1 (state == dmcc_pkg::ST_IDLE) && !run);
   pause_c: cover property ((state == dmcc_pkg::ST_XFER) && !run);
   fetch_done_c: cover property ((state == dmcc_pkg::ST_FETCH) ##1 (state == dmcc_pkg::ST_XFER));
endmodule

// ### sim/dmcc_mem_model.sv
// memory partner that serves descriptor word fetches
`timescale 1ns/1ns
module dmcc_mem_model (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // fetch port
   input wire logic mem_req_in,
   input wire logic [31:0] mem_addr_in,
   input wire logic slow_in,
   output logic mem_ready_out,
   output logic mem_rvalid_out,
   output logic [31:0] mem_rdata_out
);
   logic [31:0] mem [0:255];
   logic grant;
   logic busy;
   logic [1:0] wait_cnt;
   logic [7:0] idx;
   integer seed = 8645;
   // ==========================================================
   // accept
   // one fetch outstanding at a time, acceptance may stall when slow
   assign mem_ready_out = mem_req_in & grant & ~busy;
   // ==========================================================
   // answer
   // descriptors sit as eight aligned words; idle data toggles so stale values never match
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         grant <= 1'b0;
         busy <= 1'b0;
         wait_cnt <= 2'h0;
         idx <= 8'h00;
         mem_rvalid_out <= 1'b0;
         mem_rdata_out <= 32'h0000_0000;
      end
      else
      begin
         grant <= slow_in ? 1'($random(seed)) : 1'b1;
         mem_rvalid_out <= 1'b0;
         mem_rdata_out <= ~mem_rdata_out;
         if (busy && wait_cnt == 2'h0)
         begin
            busy <= 1'b0;
            mem_rvalid_out <= 1'b1;
            mem_rdata_out <= mem[idx];
         end
         else if (busy)
            wait_cnt <= wait_cnt - 2'h1;
         else if (mem_ready_out)
         begin
            busy <= 1'b1;
            idx <= mem_addr_in[9:2];
            wait_cnt <= slow_in ? 2'($random(seed)) : 2'h0;
         end
      end
   end
endmodule

// ### sim/tb.sv
// self-checking bench for standard descriptor chaining channel 0 and the register window of the remote channel
`timescale 1ns/1ns
module tb;
   localparam logic [31:0] B = dmcc_pkg::MAIN_BANK_BASE;
   localparam logic [31:0] EN = dmcc_pkg::MAIN_BANK_BASE + dmcc_pkg::ENABLE_OFFSET;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] addr = 32'h0000_0000;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic step = 1'b0;
   logic slow = 1'b0;
   logic vec = 1'b0;
   logic [31:0] rdata, maddr, mrdata, src, dst, rrdata;
   logic rvalid, mreq, mready, mrvalid, act;
   logic [31:0] w [0:7];
   integer seed = 8645;
   integer num_errors = 0;
   integer samples_checked = 0;
   // ==========================================================
   // instances
   dmcc_channel dut_u (.ref_clk_in(clk), .reset_n_in(rst_n), .sw_addr_in(addr), .sw_write_in(wr),
      .sw_read_in(rd), .sw_wdata_in(wdata), .sw_vector_in(vec), .sw_rdata_out(rdata), .sw_rvalid_out(rvalid),
      .mem_req_out(mreq), .mem_addr_out(maddr), .mem_ready_in(mready), .mem_rvalid_in(mrvalid),
      .mem_rdata_in(mrdata), .mover_step_in(step), .xfer_active_out(act), .xfer_source_out(src),
      .xfer_wide_destination_pointer_out(dst));
   // remote channel instance: only its register window and vector gating are exercised
   dmcc_channel #(.CHANNEL_ID(dmcc_pkg::REMOTE_CHANNEL_ID)) remote_u (.ref_clk_in(clk), .reset_n_in(rst_n),
      .sw_addr_in(addr), .sw_write_in(wr), .sw_read_in(rd), .sw_wdata_in(wdata), .sw_vector_in(vec),
      .sw_rdata_out(rrdata), .sw_rvalid_out(), .mem_req_out(), .mem_addr_out(), .mem_ready_in(1'b0),
      .mem_rvalid_in(1'b0), .mem_rdata_in(32'h0000_0000), .mover_step_in(1'b0), .xfer_active_out(),
      .xfer_source_out(), .xfer_wide_destination_pointer_out());
   dmcc_mem_model mem_u (.ref_clk_in(clk), .reset_n_in(rst_n), .mem_req_in(mreq), .mem_addr_in(maddr),
      .slow_in(slow), .mem_ready_out(mready), .mem_rvalid_out(mrvalid), .mem_rdata_out(mrdata));
   // ==========================================================
   // helpers
   always #2 clk = ~clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks=%0d errors=%0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read answers one cycle later; masked compare of the returned word
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hFFFF_FFFF);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      check({31'h0, rvalid}, 32'h0000_0001);
      check(rdata & m, exp);
   endtask
   task automatic steps(input int n);
      @(posedge clk);
      step <= 1'b1;
      repeat (n) @(posedge clk);
      step <= 1'b0;
   endtask
   task automatic wait_act(input logic exp);
      int n;
      n = 0;
      while (act !== exp && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      check({31'h0, act}, {31'h0, exp});
   endtask
   function automatic logic [31:0] len_rand();
      return 32'(((($random(seed)) & 7) + 1) * 4);
   endfunction
   function automatic logic [31:0] moved(input logic [31:0] v, input int n);
      return v + 32'(4 * n);
   endfunction
   // reserved words carry junk on purpose so the channel must ignore them
   task automatic put(input int at, input logic [31:0] len, input logic [31:0] nxt);
      for (int k = 0; k < 8; k++)
         w[k] = $random(seed);
      w[3] = len;
      w[5] = nxt;
      for (int k = 0; k < 8; k++)
         mem_u.mem[at / 4 + k] = w[k];
   endtask
   // ==========================================================
   // watchdog
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      test_done();
   end
   // ==========================================================
   // tests
   initial
   begin
      logic [31:0] la, lb;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(B, 32'h0000_0000);
      rd_chk(B + 32'h4, 32'h0000_0000);
      rd_chk(EN, 32'h0000_FFFF);
      wr_reg(B + 32'h8, 32'h1234_5678);
      rd_chk(B + 32'h8, 32'h0000_0000);
      wr_reg(B + dmcc_pkg::CHANNEL_STRIDE + 32'h4, 32'h0000_0040);
      wr_reg(dmcc_pkg::REMOTE_CHANNEL_BASE + 32'h4, 32'h0000_0060);
      rd_chk(B + 32'h4, 32'h0000_0000);
      @(posedge clk);
      vec <= 1'b1;
      rd_chk(dmcc_pkg::REMOTE_CHANNEL_BASE + 32'h4, 32'h0000_0000);
      check(rrdata, 32'h0000_0000);
      wr_reg(dmcc_pkg::REMOTE_CHANNEL_BASE + 32'h4, 32'h0000_0060);
      rd_chk(dmcc_pkg::REMOTE_CHANNEL_BASE + 32'h4, 32'h0000_0000);
      check(rrdata, 32'h0000_0060);
      @(posedge clk);
      vec <= 1'b0;
      rd_chk(dmcc_pkg::REMOTE_CHANNEL_BASE + 32'h4, 32'h0000_0000);
      check(rrdata, 32'h0000_0000);
      wr_reg(B + 32'h4, 32'h0000_00A0);
      rd_chk(B + 32'h4, 32'h0000_00A0);
      $display("test reset_and_map done");
      for (int pass = 0; pass < 2; pass++)
      begin
         slow <= pass[0];
         lb = len_rand();
         la = len_rand() + 32'h4;
         put(32'h80, lb, 32'h0);
         put(32'h40, la, 32'h80);
         wr_reg(B + 32'h4, 32'h0000_0040);
         wr_reg(B, 32'h0000_0001);
         wait_act(1'b1);
         for (int k = 0; k < 6; k++)
            rd_chk(B + 32'h8 + 32'(4 * k), w[k]);
         steps(1);
         rd_chk(B + 32'h14, la - 32'h4);
         check(src, moved(w[1], 1));
         check(dst, moved(w[2], 1));
         steps(la / 4 - 1);
         wait_act(1'b0);
         wait_act(1'b1);
         rd_chk(B + 32'h4, 32'h0000_0080);
         rd_chk(B + 32'h14, lb);
         rd_chk(B, 32'h0000_0001, 32'h0000_0001);
         steps(lb / 4);
         wait_act(1'b0);
         rd_chk(B + 32'h4, 32'h0000_0000);
         rd_chk(B, 32'h0000_0000, 32'h0000_0001);
         $display("test chain pass %0d done", pass);
      end
      slow <= 1'b0;
      la = len_rand();
      lb = len_rand();
      put(32'hC0, lb, 32'h0);
      put(32'h40, la, 32'h80);
      wr_reg(B + 32'h4, 32'h0000_0040);
      wr_reg(B, 32'h0000_0001);
      wait_act(1'b1);
      wr_reg(B, 32'h0000_0000);
      wait_act(1'b0);
      steps(1);
      wr_reg(B + 32'h1C, 32'h0000_00C0);
      rd_chk(B + 32'h14, la);
      rd_chk(B + 32'h1C, 32'h0000_00C0);
      wr_reg(B, 32'h0000_0001);
      wait_act(1'b1);
      steps(la / 4);
      wait_act(1'b0);
      wait_act(1'b1);
      rd_chk(B + 32'h4, 32'h0000_00C0);
      rd_chk(B + 32'h14, lb);
      $display("test relink_while_paused done");
      wr_reg(EN, 32'h0000_FFFE);
      wait_act(1'b0);
      steps(1);
      rd_chk(B + 32'h14, lb);
      wr_reg(EN, 32'h0000_FFFF);
      wait_act(1'b1);
      steps(lb / 4);
      wait_act(1'b0);
      rd_chk(B, 32'h0000_0000, 32'h0000_0001);
      $display("test power_disable done");
      test_done();
   end
endmodule
